// ### rtl/csd_pkg.sv
package csd_pkg;

    // bus and selector geometry
    localparam int CSD_ADDR_W   = 24;
    localparam int CSD_NUM_CS   = 8;
    localparam int CSD_CODE_W   = 2;
    localparam int CSD_NUM_WIN  = 13;
    localparam int CSD_IDX_W    = 4;
    localparam int CSD_NUM_CODE = 4;

    typedef logic [CSD_ADDR_W-1:0] csd_addr_t;
    typedef logic [CSD_CODE_W-1:0] csd_code_t;
    typedef logic [CSD_IDX_W-1:0]  csd_idx_t;

    // area code values
    localparam csd_code_t CSD_CODE_00 = 2'h0;
    localparam csd_code_t CSD_CODE_01 = 2'h1;
    localparam csd_code_t CSD_CODE_10 = 2'h2;
    localparam csd_code_t CSD_CODE_11 = 2'h3;

    // area code held after reset for every selector
    localparam csd_code_t CSD_CODE_RST = CSD_CODE_00;

    // window sizes in bytes
    localparam csd_addr_t CSD_SZ_1M   = 24'h10_0000;
    localparam csd_addr_t CSD_SZ_512K = 24'h08_0000;
    localparam csd_addr_t CSD_SZ_128K = 24'h02_0000;
    localparam csd_addr_t CSD_SZ_4K   = 24'h00_1000;
    localparam csd_addr_t CSD_SZ_2K   = 24'h00_0800;
    localparam csd_addr_t CSD_SZ_128B = 24'h00_0080;

    // window indices
    localparam csd_idx_t W_F0_1M   = 4'h0;
    localparam csd_idx_t W_F8_512K = 4'h1;
    localparam csd_idx_t W_FE_128K = 4'h2;
    localparam csd_idx_t W_E0_1M   = 4'h3;
    localparam csd_idx_t W_FC_128K = 4'h4;
    localparam csd_idx_t W_IO_FF80 = 4'h5;
    localparam csd_idx_t W_FA_128K = 4'h6;
    localparam csd_idx_t W_30_4K   = 4'h7;
    localparam csd_idx_t W_IO_FF00 = 4'h8;
    localparam csd_idx_t W_F8_128K = 4'h9;
    localparam csd_idx_t W_IO_FE80 = 4'hA;
    localparam csd_idx_t W_28_2K   = 4'hB;
    localparam csd_idx_t W_F0_512K = 4'hC;
    localparam csd_idx_t W_NONE    = 4'hF;

    // window base addresses, by index
    localparam csd_addr_t CSD_WIN_BASE [CSD_NUM_WIN] = '{
        24'hF0_0000, 24'hF8_0000, 24'hFE_0000, 24'hE0_0000, 24'hFC_0000,
        24'h68_FF80, 24'hFA_0000, 24'h00_3000, 24'h68_FF00, 24'hF8_0000,
        24'h68_FE80, 24'h00_2800, 24'hF0_0000};

    // window sizes, by index
    localparam csd_addr_t CSD_WIN_SIZE [CSD_NUM_WIN] = '{
        CSD_SZ_1M, CSD_SZ_512K, CSD_SZ_128K, CSD_SZ_1M, CSD_SZ_128K,
        CSD_SZ_128B, CSD_SZ_128K, CSD_SZ_4K, CSD_SZ_128B, CSD_SZ_128K,
        CSD_SZ_128B, CSD_SZ_2K, CSD_SZ_512K};

    // window chosen by each selector for codes 00, 01, 10, 11
    localparam csd_idx_t CSD_MAP [CSD_NUM_CS][CSD_NUM_CODE] = '{
        '{W_F0_1M,   W_F8_512K, W_FE_128K, W_NONE},
        '{W_E0_1M,   W_F0_512K, W_FC_128K, W_IO_FF80},
        '{W_30_4K,   W_FA_128K, W_IO_FF80, W_IO_FF00},
        '{W_F8_128K, W_IO_FF00, W_IO_FE80, W_NONE},
        '{W_28_2K,   W_IO_FE80, W_NONE,    W_NONE},
        '{W_IO_FF80, W_NONE,    W_NONE,    W_NONE},
        '{W_IO_FF00, W_NONE,    W_NONE,    W_NONE},
        '{W_NONE,    W_NONE,    W_NONE,    W_NONE}};

    // selector that also serves boot and vector fetches
    localparam int CSD_BOOT_CS = 0;

endpackage

// ### rtl/csd_window.sv
`timescale 1ns/1ns

// flags an address inside one aligned window
module csd_window #(
    parameter logic [23:0] BASE = 24'h00_0000,
    parameter logic [23:0] SIZE = 24'h00_0080
) (
    // address under test
    input  wire logic [23:0] addr,
    // match flag
    output wire logic        hit
);

    // aligned windows need only the bits above the span
    assign hit = ((addr ^ BASE) & ~(SIZE - 24'h00_0001)) == 24'h00_0000;

endmodule

// ### rtl/csd_decoder.sv
`timescale 1ns/1ns

// Overview of operation
// - eight select outputs exist, each with its own two-bit area code choosing its window.
// - a select output is active the cycle after a bus access address lies in its window, else inactive.
// - output 0 decodes 1M at F00000, 512K at F80000, 128K at FE0000, or is off for code 11.
// - output 0 is also active during program ROM fetches and vector fetches.
// - output 1 decodes 1M at E00000, 512K at F00000, 128K at FC0000, or 128B at 68FF80.
// - output 2 decodes 4K at 003000, 128K at FA0000, 128B at 68FF80, or 128B at 68FF00.
// - output 3 decodes 128K at F80000, 128B at 68FF00, 128B at 68FE80, or is off for code 11.
// - output 4 decodes 2K at 002800 or 128B at 68FE80, and is off for codes 10 and 11.
// - outputs 5 and 6 decode 128B at 68FF80 and 68FF00 for code 00 only; output 7 never fires.
module csd_decoder
    import csd_pkg::*;
(
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    // bus access from the core
    input  wire logic                     bus_access_valid,
    input  wire csd_pkg::csd_addr_t       bus_addr,
    input  wire logic                     rom_fetch,
    input  wire logic                     vector_fetch,
    // area code control bits
    input  wire logic                     area_wr_en,
    input  wire logic [2:0]               area_wr_sel,
    input  wire csd_pkg::csd_code_t       area_wr_code,
    output wire logic [15:0]              area_code_rd,
    // chip selects, active high
    output wire logic                     chip_select_out_0,
    output wire logic                     chip_select_out_1,
    output wire logic                     chip_select_out_2,
    output wire logic                     chip_select_out_3,
    output wire logic                     chip_select_out_4,
    output wire logic                     chip_select_out_5,
    output wire logic                     chip_select_out_6,
    output wire logic                     chip_select_out_7
);
    import csd_pkg::*;

    csd_code_t                 area_code_reg [CSD_NUM_CS];
    logic [CSD_NUM_CS-1:0]     cs_reg;
    logic [CSD_NUM_CS-1:0]     cs_next;
    logic [CSD_NUM_WIN-1:0]    win_hit;
    logic [15:0]               area_rd_reg;
    logic                      boot_fetch;

    // picks the hit flag of a window index, none never hits
    function automatic logic csd_route(input csd_idx_t idx,
                                       input logic [CSD_NUM_WIN-1:0] hits);
        logic r;
        r = 1'b0;
        if (idx != W_NONE) begin
            r = hits[idx];
        end
        return r;
    endfunction

    // one comparator per distinct window
    for (genvar g = 0; g < CSD_NUM_WIN; g++) begin : g_win
        csd_window #(
            .BASE (CSD_WIN_BASE[g]),
            .SIZE (CSD_WIN_SIZE[g])
        ) u_win (
            .addr (bus_addr),
            .hit  (win_hit[g])
        );
    end

    // per-selector area code storage
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < CSD_NUM_CS; i++) begin
                area_code_reg[i] <= CSD_CODE_RST;
            end
        end else if (area_wr_en) begin
            area_code_reg[area_wr_sel] <= area_wr_code;
        end
    end

    // readback image of all area codes
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            area_rd_reg <= 16'h0000;
        end else begin
            for (int i = 0; i < CSD_NUM_CS; i++) begin
                area_rd_reg[i*CSD_CODE_W +: CSD_CODE_W] <= area_code_reg[i];
            end
        end
    end

    assign boot_fetch = rom_fetch | vector_fetch;

    // window decode through each selector's table row
    always_comb begin
        cs_next = '0;
        for (int i = 0; i < CSD_NUM_CS; i++) begin
            cs_next[i] = bus_access_valid & csd_route(CSD_MAP[i][area_code_reg[i]], win_hit);
        end
        if (bus_access_valid && boot_fetch) begin
            cs_next[CSD_BOOT_CS] = 1'b1;
        end
    end

    // registered selects, idle in reset
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cs_reg <= '0;
        end else begin
            cs_reg <= cs_next;
        end
    end

    // outputs straight from flops
    assign area_code_rd      = area_rd_reg;
    assign chip_select_out_0 = cs_reg[0];
    assign chip_select_out_1 = cs_reg[1];
    assign chip_select_out_2 = cs_reg[2];
    assign chip_select_out_3 = cs_reg[3];
    assign chip_select_out_4 = cs_reg[4];
    assign chip_select_out_5 = cs_reg[5];
    assign chip_select_out_6 = cs_reg[6];
    assign chip_select_out_7 = cs_reg[7];

    // checks
    sequence acc_s(logic [23:0] base, logic [23:0] size);
        bus_access_valid && !boot_fetch && bus_addr >= base && bus_addr <= base + (size - 24'h1);
    endsequence

    sequence code_s(int n, csd_code_t c);
        area_code_reg[n] == c;
    endsequence

    reset_idle_a: assert property (@(posedge mclk)
        $rose(rst_b) |-> cs_reg == '0)
        else $error("selects not idle after reset");

    no_access_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !bus_access_valid |=> cs_reg == '0)
        else $error("select active without access");

    code_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        area_wr_en |=> ##1 area_code_rd[$past(area_wr_sel, 2)*2 +: 2] == $past(area_wr_code, 2))
        else $error("area code not stored");

    cs0_window_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(0, CSD_CODE_10) and acc_s(24'hFE_0000, 24'h02_0000) |=> chip_select_out_0)
        else $error("output 0 missed its window");

    cs0_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(0, CSD_CODE_11) and (!boot_fetch) |=> !chip_select_out_0)
        else $error("output 0 active while disabled");

    boot_fetch_a: assert property (@(posedge mclk) disable iff (!rst_b)
        bus_access_valid && boot_fetch |=> chip_select_out_0)
        else $error("output 0 missed boot fetch");

    cs0_wide_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(0, CSD_CODE_00) and acc_s(24'hF0_0000, 24'h10_0000) |=> chip_select_out_0)
        else $error("output 0 missed its wide window");

    cs1_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(1, CSD_CODE_00) and acc_s(24'hE0_0000, 24'h10_0000) |=> chip_select_out_1)
        else $error("output 1 missed its wide window");

    cs1_io_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(1, CSD_CODE_11) and acc_s(24'h68_FF80, 24'h00_0080) |=> chip_select_out_1)
        else $error("output 1 missed io window");

    cs2_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(2, CSD_CODE_00) and acc_s(24'h00_3000, 24'h00_1000) |=> chip_select_out_2)
        else $error("output 2 missed its window");

    cs2_io_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(2, CSD_CODE_11) and acc_s(24'h68_FF00, 24'h00_0080) |=> chip_select_out_2)
        else $error("output 2 missed io window");

    cs3_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(3, CSD_CODE_00) and acc_s(24'hF8_0000, 24'h02_0000) |=> chip_select_out_3)
        else $error("output 3 missed its window");

    cs3_io_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(3, CSD_CODE_10) and acc_s(24'h68_FE80, 24'h00_0080) |=> chip_select_out_3)
        else $error("output 3 missed io window");

    cs3_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        area_code_reg[3] == CSD_CODE_11 |=> !chip_select_out_3)
        else $error("output 3 active while disabled");

    cs4_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(4, CSD_CODE_00) and acc_s(24'h00_2800, 24'h00_0800) |=> chip_select_out_4)
        else $error("output 4 missed its window");

    cs4_io_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(4, CSD_CODE_01) and acc_s(24'h68_FE80, 24'h00_0080) |=> chip_select_out_4)
        else $error("output 4 missed io window");

    cs4_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        area_code_reg[4][1] |=> !chip_select_out_4)
        else $error("output 4 active while disabled");

    cs5_window_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(5, CSD_CODE_00) and acc_s(24'h68_FF80, 24'h00_0080) |=> chip_select_out_5)
        else $error("output 5 missed its window");

    cs6_window_a: assert property (@(posedge mclk) disable iff (!rst_b)
        code_s(6, CSD_CODE_00) and acc_s(24'h68_FF00, 24'h00_0080) |=> chip_select_out_6)
        else $error("output 6 missed its window");

    cs5_cs6_a: assert property (@(posedge mclk) disable iff (!rst_b)
        area_code_reg[5] != CSD_CODE_00 && area_code_reg[6] != CSD_CODE_00
        |=> !chip_select_out_5 && !chip_select_out_6)
        else $error("output 5 or 6 active while disabled");

    cs7_never_a: assert property (@(posedge mclk) disable iff (!rst_b)
        1'b1 |=> !chip_select_out_7)
        else $error("output 7 asserted");

    outside_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
        bus_access_valid && !boot_fetch && win_hit == '0 |=> cs_reg == '0)
        else $error("select active outside every window");

endmodule

// ### testbench/csd_ext_devs.sv
`timescale 1ns/1ns

// external memories and i/o devices, records which selects have fired
module csd_ext_devs (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // chip selects from the decoder
    input  wire logic [7:0] cs_in,
    // sticky record of selects seen
    output var  logic [7:0] seen_reg
);
    // each device latches that it was addressed
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            seen_reg <= 8'h00;
        end else begin
            seen_reg <= seen_reg | cs_in;
        end
    end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module testbench;
    import csd_pkg::*;
    typedef struct packed {
        csd_code_t  code;
        csd_addr_t  addr;
        logic [1:0] fetch;
        logic [7:0] exp;
    } csd_row_t;
    // all selectors share one code; fetch is {rom, vector}
    localparam csd_row_t ROWS [25] = '{
        '{2'h0, 24'hF0_0010, 2'h0, 8'h01}, '{2'h0, 24'h68_FF80, 2'h0, 8'h20},
        '{2'h0, 24'h68_FF00, 2'h0, 8'h40}, '{2'h0, 24'h00_3FFF, 2'h0, 8'h04},
        '{2'h0, 24'h00_4000, 2'h0, 8'h00}, '{2'h0, 24'h00_2800, 2'h0, 8'h10},
        '{2'h0, 24'h00_27FF, 2'h0, 8'h00}, '{2'h0, 24'hE0_0000, 2'h0, 8'h02},
        '{2'h0, 24'hF8_0000, 2'h0, 8'h09}, '{2'h0, 24'hEF_FFFF, 2'h0, 8'h02},
        '{2'h1, 24'hF8_0000, 2'h0, 8'h01}, '{2'h1, 24'hF7_FFFF, 2'h0, 8'h02},
        '{2'h1, 24'hFA_0000, 2'h0, 8'h05}, '{2'h1, 24'h68_FF00, 2'h0, 8'h08},
        '{2'h1, 24'h68_FE80, 2'h0, 8'h10}, '{2'h2, 24'hFE_0000, 2'h0, 8'h01},
        '{2'h2, 24'hFC_0000, 2'h0, 8'h02}, '{2'h2, 24'h68_FF80, 2'h0, 8'h04},
        '{2'h2, 24'h68_FE80, 2'h0, 8'h08}, '{2'h2, 24'hFD_FFFF, 2'h0, 8'h02},
        '{2'h3, 24'h68_FF80, 2'h0, 8'h02}, '{2'h3, 24'h68_FF00, 2'h0, 8'h04},
        '{2'h3, 24'hFF_FFFF, 2'h0, 8'h00}, '{2'h3, 24'h00_0000, 2'h2, 8'h01},
        '{2'h3, 24'h00_0000, 2'h1, 8'h01}};

    logic       mclk, rst_b, valid, rom, vec, wr_en;
    csd_addr_t  addr;
    logic [2:0] wsel;
    csd_code_t  wcode;
    wire [15:0] rd;
    wire [7:0]  cs, seen;
    int         failures, n_tests;

    // device under test and far-side devices
    csd_decoder i_dut (.mclk(mclk), .rst_b(rst_b), .bus_access_valid(valid), .bus_addr(addr),
        .rom_fetch(rom), .vector_fetch(vec), .area_wr_en(wr_en), .area_wr_sel(wsel),
        .area_wr_code(wcode), .area_code_rd(rd), .chip_select_out_0(cs[0]),
        .chip_select_out_1(cs[1]), .chip_select_out_2(cs[2]), .chip_select_out_3(cs[3]),
        .chip_select_out_4(cs[4]), .chip_select_out_5(cs[5]), .chip_select_out_6(cs[6]),
        .chip_select_out_7(cs[7]));
    csd_ext_devs i_devs (.mclk(mclk), .rst_b(rst_b), .cs_in(cs), .seen_reg(seen));

    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // verdict and end of run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // back-to-back writes of one code to all selectors
    task automatic wr_all(input csd_code_t c);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            wr_en <= 1'b1;
            wsel  <= i[2:0];
            wcode <= c;
        end
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    // one-cycle access; selects are settled on return
    task automatic acc(input csd_addr_t a, input logic [1:0] f);
        @(posedge mclk);
        valid <= 1'b1;
        addr  <= a;
        rom   <= f[1];
        vec   <= f[0];
        @(posedge mclk);
        valid <= 1'b0;
        rom   <= 1'b0;
        vec   <= 1'b0;
        #1;
    endtask

    // hang guard
    initial begin
        #500000;
        failures++;
        print_verdict();
    end

    initial begin
        {rom, vec, wr_en, wsel, wcode} = '0;
        failures = 0;
        n_tests  = 0;
        rst_b = 1'b0;
        valid = 1'b1;
        addr  = 24'hF0_0000;
        repeat (7) @(posedge mclk);
        #1;
        `CHK("cs in reset", 8'h00, cs);
        `CHK("codes in reset", 16'h0000, rd);
        @(posedge mclk);
        rst_b <= 1'b1;
        valid <= 1'b0;
        $display("test reset done");
        for (int r = 0; r < 25; r++) begin
            wr_all(ROWS[r].code);
            acc(ROWS[r].addr, ROWS[r].fetch);
            `CHK("cs lo", ROWS[r].exp[3:0], cs[3:0]);
            `CHK("cs hi", ROWS[r].exp[7:4], cs[7:4]);
        end
        @(posedge mclk);
        #1;
        `CHK("cs idle", 8'h00, cs);
        `CHK("selects seen", 8'h7F, seen);
        $display("test table done");
        wr_all(2'h0);
        @(posedge mclk);
        valid <= 1'b1;
        addr  <= 24'h00_3000;
        @(posedge mclk);
        addr  <= 24'h00_2800;
        #1;
        `CHK("cs first", 8'h04, cs);
        @(posedge mclk);
        valid <= 1'b0;
        #1;
        `CHK("cs second", 8'h10, cs);
        @(posedge mclk);
        #1;
        `CHK("cs after", 8'h00, cs);
        $display("test back to back done");
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            wr_en <= 1'b1;
            wsel  <= i[2:0];
            wcode <= i[1:0];
        end
        @(posedge mclk);
        wr_en <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("code readback", 16'hE4E4, rd);
        acc(24'h68_FF80, 2'h0);
        `CHK("cs mixed codes", 8'h04, cs);
        $display("test mixed codes done");
        @(posedge mclk);
        rst_b <= 1'b0;
        valid <= 1'b1;
        addr  <= 24'h68_FF80;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("cs second reset", 8'h00, cs);
        `CHK("codes second reset", 16'h0000, rd);
        @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        valid <= 1'b0;
        #1;
        `CHK("cs reset code", 8'h20, cs);
        $display("test second reset done");
        print_verdict();
    end
endmodule
